/* fca_pkg.sv */
package fca_pkg;
	// command codes
	localparam logic [7:0] CMD_MISC_READ    = 8'h03;
	localparam logic [7:0] CMD_ERASE        = 8'h04;
	localparam logic [7:0] CMD_SECTOR_CRC   = 8'h05;
	localparam logic [7:0] CMD_GLOBAL_CRC   = 8'h06;
	localparam logic [7:0] CMD_READ_CODE    = 8'h07;
	// misc read addresses
	localparam logic [7:0] ADR_CFG_ONE      = 8'h00;
	localparam logic [7:0] ADR_CFG_TWO      = 8'h01;
	localparam logic [7:0] ADR_BOOT_VECTOR  = 8'h02;
	localparam logic [7:0] ADR_STATUS_BYTE  = 8'h03;
	localparam logic [7:0] ADR_SEC_FIRST    = 8'h08;
	localparam logic [7:0] ADR_SEC_LAST     = 8'h0f;
	// erase selectors
	localparam logic [7:0] ERASE_PAGE       = 8'h00;
	localparam logic [7:0] ERASE_SECTOR     = 8'h01;
	// config byte one fields
	localparam int CFG1_DBL_BIT             = 7;
	localparam int CFG1_RPE_BIT             = 6;
	localparam int CFG1_BO_LSB              = 3;
	localparam int CFG1_OSC_LSB             = 0;
	localparam logic [7:0] CFG1_RESET       = 8'h6b;
	// config byte two fields
	localparam int CFG2_WDRE_BIT            = 7;
	localparam int CFG2_WATCHDOG_SAFETY_ENABLE_BIT            = 1;
	localparam logic [7:0] CFG2_RESET       = 8'h00;
	// error status bits
	localparam int ERR_OI_BIT               = 0;
	localparam int ERR_SV_BIT               = 1;
	localparam int ERR_HVE_BIT              = 2;
	localparam int ERR_VE_BIT               = 3;
	localparam logic [7:0] ERR_MASK         = 8'h0f;
	// oscillator select encodings
	localparam logic [2:0] OSC_EXT_CLK      = 3'h7;
	localparam logic [2:0] OSC_WDOG         = 3'h4;
	localparam logic [2:0] OSC_INT_RC       = 3'h3;
	localparam logic [2:0] OSC_LF_XTAL      = 3'h2;
	localparam logic [2:0] OSC_MF_XTAL      = 3'h1;
	localparam logic [2:0] OSC_HF_XTAL      = 3'h0;
	// one-hot clock source select
	localparam int SRC_EXT = 0;
	localparam int SRC_WDG = 1;
	localparam int SRC_RC  = 2;
	localparam int SRC_LF  = 3;
	localparam int SRC_MF  = 4;
	localparam int SRC_HF  = 5;
	localparam logic [5:0] SRC_RESET        = 6'h04;
	typedef enum logic [2:0] {
		FCA_LOAD1 = 3'b000,
		FCA_LOAD2 = 3'b001,
		FCA_IDLE  = 3'b011,
		FCA_BUSY  = 3'b010,
		FCA_DONE  = 3'b110
	} fca_state_t;
endpackage

/* fca_cfg_decode.sv */
`timescale 1ns/1ps
module fca_cfg_decode
	import fca_pkg::*;
(
	// clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_sys_rst,
	// latched configuration
	input  wire logic [7:0] i_cfg_one,
	input  wire logic [7:0] i_cfg_two,
	input  wire logic       i_pwr_done,
	// shared pin and watchdog
	input  wire logic       i_shared_pin,
	input  wire logic       i_wdog_timeout,
	// decoded outputs
	output logic [5:0]      o_clk_src_sel,
	output logic            o_rc_clock_doubler,
	output logic [2:0]      o_brownout_cfg,
	output logic            o_ext_reset,
	output logic            o_pin_input,
	output logic            o_wdog_reset,
	output logic            o_wdog_irq,
	output logic            o_watchdog_safety_enable
);
	logic       pin_is_reset;
	logic [5:0] next_src;

	always_comb begin
		next_src = 6'h00;
		// (R9) oscillator decode
		case (i_cfg_one[CFG1_OSC_LSB +: 3])
			OSC_EXT_CLK: next_src[SRC_EXT] = 1'b1;
			OSC_WDOG:    next_src[SRC_WDG] = 1'b1;
			OSC_INT_RC:  next_src[SRC_RC] = 1'b1;
			OSC_LF_XTAL: next_src[SRC_LF] = 1'b1;
			OSC_MF_XTAL: next_src[SRC_MF] = 1'b1;
			OSC_HF_XTAL: next_src[SRC_HF] = 1'b1;
			// (R10) reserved codes fall back to rc
			default:     next_src[SRC_RC] = 1'b1;
		endcase
	end

	// (R12) pin forced to reset during power-up
	// (R13) only power-up overrides the enable
	assign pin_is_reset = !i_pwr_done || i_cfg_one[CFG1_RPE_BIT];

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_clk_src_sel      <= SRC_RESET;
			o_rc_clock_doubler <= 1'b0;
			o_brownout_cfg     <= 3'h0;
		end else begin
			// (R19) decode from holding latches
			o_clk_src_sel      <= next_src;
			// (R14) doubler only on rc source
			o_rc_clock_doubler <= i_cfg_one[CFG1_DBL_BIT] && next_src[SRC_RC];
			// (R8) byte one field layout
			o_brownout_cfg     <= i_cfg_one[CFG1_BO_LSB +: 3];
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_ext_reset <= 1'b0;
			o_pin_input <= 1'b0;
		end else begin
			// (R11) pin function select
			o_ext_reset <= pin_is_reset && i_shared_pin;
			o_pin_input <= pin_is_reset ? 1'b0 : i_shared_pin;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_wdog_reset             <= 1'b0;
			o_wdog_irq               <= 1'b0;
			o_watchdog_safety_enable <= 1'b0;
		end else begin
			// (R16) watchdog reset or interrupt only
			o_wdog_reset             <= i_wdog_timeout && i_cfg_two[CFG2_WDRE_BIT];
			o_wdog_irq               <= i_wdog_timeout && !i_cfg_two[CFG2_WDRE_BIT];
			o_watchdog_safety_enable <= i_cfg_two[CFG2_WATCHDOG_SAFETY_ENABLE_BIT];
		end
	end

	chk_dbl_rc_only: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R14
		o_rc_clock_doubler |-> o_clk_src_sel[SRC_RC])
		else $error("doubler active without rc source");
	chk_pin_powerup: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R12
		!i_pwr_done |=> !o_pin_input)
		else $error("pin used as input during power-up");
	chk_wdog_route: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R16
		i_wdog_timeout && !i_cfg_two[CFG2_WDRE_BIT] |=> !o_wdog_reset && o_wdog_irq)
		else $error("watchdog reset while disabled");
	cov_wdog_reset: cover property (@(posedge i_clk) disable iff (i_sys_rst) o_wdog_reset);
endmodule

/* fca_iap_core.sv */
`timescale 1ns/1ps
// Behaviour
// (R1) command 03h reads config, boot, status, security
// (R2) read returns byte, else error status
// (R3) command 04h erases page or sector
// (R4) carry set on error, cleared otherwise
// (R5) command 05h returns sector crc bytes
// (R6) command 06h returns global crc bytes
// (R7) config bytes fixed after power-up
// (R8) config byte one field layout, 6bh
// (R9) oscillator select picks clock source
// (R10) software avoids reserved oscillator codes
// (R11) reset enable picks pin function
// (R12) power-up forces pin as reset
// (R13) other resets keep pin selection
// (R14) doubler doubles internal rc clock
// (R15) config byte two watchdog bits
// (R16) watchdog reset enable gates timeout reset
// (R17) error status bit layout, upper zero
// (R18) reserved read address sets carry, error
// (R19) power-up copies config into latches
module fca_iap_core
	import fca_pkg::*;
(
	// clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_sys_rst,
	// command side
	input  wire logic        i_cmd_valid,
	input  wire logic [7:0]  i_cmd_code,
	input  wire logic [7:0]  i_arg_hi,
	input  wire logic [7:0]  i_arg_lo,
	input  wire logic [7:0]  i_arg_sel,
	input  wire logic        i_key_ok,
	input  wire logic        i_irq_pending,
	output logic             o_cmd_busy,
	output logic             o_cmd_done,
	output logic             o_carry,
	output logic [7:0]       o_res_b3,
	output logic [7:0]       o_res_b2,
	output logic [7:0]       o_res_b1,
	output logic [7:0]       o_res_b0,
	output logic             o_cpu_release,
	// flash array side
	output logic             o_fl_cfg_rd,
	output logic [7:0]       o_fl_cfg_addr,
	input  wire logic [7:0]  i_fl_cfg_data,
	output logic             o_fl_req,
	output logic [7:0]       o_fl_cmd,
	output logic [15:0]      o_fl_addr,
	output logic [7:0]       o_fl_sel,
	input  wire logic        i_fl_done,
	input  wire logic [31:0] i_fl_result,
	input  wire logic [3:0]  i_fl_err,
	// pins and watchdog
	input  wire logic        i_shared_pin,
	input  wire logic        i_wdog_timeout,
	// decoded configuration
	output logic [5:0]       o_clk_src_sel,
	output logic             o_rc_clock_doubler,
	output logic [2:0]       o_brownout_cfg,
	output logic             o_ext_reset,
	output logic             o_pin_input,
	output logic             o_wdog_reset,
	output logic             o_wdog_irq,
	output logic             o_watchdog_safety_enable
);
	fca_state_t  state;
	logic [7:0]  user_config_byte_one;
	logic [7:0]  user_config_byte_two;
	logic        pwr_done;
	logic [7:0]  cmd;
	logic [7:0]  sel;
	logic        fl_end;

	function automatic logic is_reserved(input logic [7:0] a);
		is_reserved = !(a <= ADR_STATUS_BYTE || (a >= ADR_SEC_FIRST && a <= ADR_SEC_LAST));
	endfunction

	function automatic logic is_flash_cmd(input logic [7:0] c);
		is_flash_cmd = (c == CMD_ERASE || c == CMD_SECTOR_CRC ||
			c == CMD_GLOBAL_CRC || c == CMD_READ_CODE);
	endfunction

	// wait ends on done or abort, at once when no array request was issued
	assign fl_end = !o_fl_req || i_fl_done || i_irq_pending;

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			state <= FCA_LOAD1;
		end else begin
			case (state)
				FCA_LOAD1: begin
					state <= FCA_LOAD2;
				end
				FCA_LOAD2: begin
					state <= FCA_IDLE;
				end
				FCA_IDLE: begin
					if (i_cmd_valid) begin
						state <= FCA_BUSY;
					end
				end
				FCA_BUSY: begin
					if (fl_end) begin
						state <= FCA_DONE;
					end
				end
				default: begin
					state <= FCA_IDLE;
				end
			endcase
		end
	end

	// (R19) copy config bytes before release
	// (R7) latches written only during load
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			user_config_byte_one <= CFG1_RESET;
			user_config_byte_two <= CFG2_RESET;
			pwr_done             <= 1'b0;
		end else begin
			if (state == FCA_LOAD1) begin
				user_config_byte_one <= i_fl_cfg_data;
			end
			if (state == FCA_LOAD2) begin
				// (R15) only the two watchdog bits kept
				user_config_byte_two <= i_fl_cfg_data &
					((8'h01 << CFG2_WDRE_BIT) | (8'h01 << CFG2_WATCHDOG_SAFETY_ENABLE_BIT));
				pwr_done <= 1'b1;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_fl_cfg_rd   <= 1'b1;
			o_fl_cfg_addr <= ADR_CFG_ONE;
		end else if (state == FCA_LOAD1) begin
			o_fl_cfg_addr <= ADR_CFG_TWO;
		end else if (state == FCA_IDLE && i_cmd_valid && i_cmd_code == CMD_MISC_READ) begin
			o_fl_cfg_rd   <= 1'b1;
			o_fl_cfg_addr <= i_arg_sel;
		end else begin
			o_fl_cfg_rd   <= 1'b0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			cmd <= 8'h00;
			sel <= 8'h00;
		end else if (state == FCA_IDLE && i_cmd_valid) begin
			cmd <= i_cmd_code;
			sel <= i_arg_sel;
		end
	end

	// (R3) erase and crc requests go to the array
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_fl_req  <= 1'b0;
			o_fl_cmd  <= 8'h00;
			o_fl_addr <= 16'h0000;
			o_fl_sel  <= 8'h00;
		end else if (state == FCA_IDLE && i_cmd_valid) begin
			o_fl_req  <= is_flash_cmd(i_cmd_code) &&
				(i_cmd_code != CMD_ERASE ||
				(i_key_ok && i_arg_sel <= ERASE_SECTOR));
			o_fl_cmd  <= i_cmd_code;
			o_fl_addr <= {i_arg_hi, i_arg_lo};
			o_fl_sel  <= i_arg_sel;
		end else if (state != FCA_BUSY || i_fl_done || i_irq_pending) begin
			o_fl_req  <= 1'b0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_cmd_busy <= 1'b0;
			o_cmd_done <= 1'b0;
		end else begin
			o_cmd_busy <= (state == FCA_IDLE && i_cmd_valid) ||
				(state == FCA_BUSY && !fl_end);
			o_cmd_done <= state == FCA_BUSY && fl_end;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_carry  <= 1'b0;
			o_res_b3 <= 8'h00;
			o_res_b2 <= 8'h00;
			o_res_b1 <= 8'h00;
			o_res_b0 <= 8'h00;
		end else if (state == FCA_BUSY) begin
			if (cmd == CMD_MISC_READ) begin
				// (R18) reserved address flags security error
				// (R2) byte or error status in result
				if (is_reserved(sel)) begin
					o_carry  <= 1'b1;
					o_res_b0 <= 8'h01 << ERR_SV_BIT;
				end else begin
					o_carry <= 1'b0;
					// (R1) config bytes from latches, rest from flash
					if (sel == ADR_CFG_ONE) begin
						o_res_b0 <= user_config_byte_one;
					end else if (sel == ADR_CFG_TWO) begin
						o_res_b0 <= user_config_byte_two;
					end else begin
						o_res_b0 <= i_fl_cfg_data;
					end
				end
			end else if (cmd == CMD_ERASE && !o_fl_req) begin
				o_carry  <= 1'b1;
				o_res_b0 <= 8'h01 << ERR_SV_BIT;
			end else if (o_fl_req && i_irq_pending && !i_fl_done) begin
				// (R17) interrupted operation status
				o_carry  <= 1'b1;
				o_res_b0 <= 8'h01 << ERR_OI_BIT;
			end else if (o_fl_req && i_fl_done) begin
				// (R4) carry from error flags
				o_carry <= |i_fl_err;
				// (R5) (R6) crc bytes, status replaces low byte
				o_res_b3 <= i_fl_result[31:24];
				o_res_b2 <= i_fl_result[23:16];
				o_res_b1 <= i_fl_result[15:8];
				o_res_b0 <= (|i_fl_err) ? ({4'h0, i_fl_err} & ERR_MASK) : i_fl_result[7:0];
			end else if (!is_flash_cmd(cmd)) begin
				o_carry <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_cpu_release <= 1'b0;
		end else begin
			o_cpu_release <= pwr_done;
		end
	end

	fca_cfg_decode u_decode (
		.i_clk                    (i_clk),
		.i_sys_rst                (i_sys_rst),
		.i_cfg_one                (user_config_byte_one),
		.i_cfg_two                (user_config_byte_two),
		.i_pwr_done               (pwr_done),
		.i_shared_pin             (i_shared_pin),
		.i_wdog_timeout           (i_wdog_timeout),
		.o_clk_src_sel            (o_clk_src_sel),
		.o_rc_clock_doubler       (o_rc_clock_doubler),
		.o_brownout_cfg           (o_brownout_cfg),
		.o_ext_reset              (o_ext_reset),
		.o_pin_input              (o_pin_input),
		.o_wdog_reset             (o_wdog_reset),
		.o_wdog_irq               (o_wdog_irq),
		.o_watchdog_safety_enable (o_watchdog_safety_enable)
	);

	chk_reserved_read: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R18
		state == FCA_BUSY && cmd == CMD_MISC_READ && is_reserved(sel)
		|=> o_carry && o_res_b0 != 8'h00 && o_cmd_done)
		else $error("reserved read did not flag error");
	chk_read_latch: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R2
		state == FCA_BUSY && cmd == CMD_MISC_READ && sel == ADR_CFG_ONE
		|=> !o_carry && o_res_b0 == user_config_byte_one)
		else $error("config read returned wrong byte");
	chk_cfg_frozen: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R7
		pwr_done && $past(pwr_done) |-> $stable(user_config_byte_one))
		else $error("config latch changed after power-up");
	chk_erase_nokey: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R3
		state == FCA_IDLE && i_cmd_valid && i_cmd_code == CMD_ERASE && !i_key_ok
		|=> !o_fl_req ##1 o_carry)
		else $error("erase started without key");
	chk_erase_badsel: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R3
		state == FCA_IDLE && i_cmd_valid && i_cmd_code == CMD_ERASE && i_arg_sel > ERASE_SECTOR
		|=> !o_fl_req ##1 o_carry && o_res_b0 == (8'h01 << ERR_SV_BIT))
		else $error("erase with bad selector started");
	chk_crc_status: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R5
		state == FCA_BUSY && cmd == CMD_SECTOR_CRC && i_fl_done && |i_fl_err
		|=> o_carry && o_res_b0[7:4] == 4'h0)
		else $error("crc error status wrong");
	chk_crc_ok: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R6
		state == FCA_BUSY && cmd == CMD_GLOBAL_CRC && i_fl_done && i_fl_err == 4'h0
		|=> !o_carry && o_res_b3 == $past(i_fl_result[31:24]))
		else $error("global crc result wrong");
	chk_irq_abort: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R4
		state == FCA_BUSY && o_fl_req && i_irq_pending && !i_fl_done
		|=> o_carry && o_res_b0[ERR_OI_BIT])
		else $error("interrupted op not flagged");
	chk_done_pulse: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R4
		o_cmd_done |=> !o_cmd_done && !o_cmd_busy)
		else $error("done held longer than one cycle");
	chk_cpu_hold: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R19
		$rose(o_cpu_release) |-> $past(pwr_done))
		else $error("cpu released before config loaded");
	cov_irq_abort: cover property (@(posedge i_clk) disable iff (i_sys_rst)
		o_cmd_done && o_carry && o_res_b0[ERR_OI_BIT]);
	cov_misc_read: cover property (@(posedge i_clk) disable iff (i_sys_rst)
		o_cmd_done && cmd == CMD_MISC_READ && !o_carry);
	cov_erase: cover property (@(posedge i_clk) disable iff (i_sys_rst)
		o_cmd_done && cmd == CMD_ERASE);
	cov_crc_err: cover property (@(posedge i_clk) disable iff (i_sys_rst)
		o_cmd_done && cmd == CMD_SECTOR_CRC && o_carry);
endmodule

/* fca_flash_model.sv */
`timescale 1ns/1ps
module fca_flash_model (
	// clock and setup
	input  wire logic        i_clk,
	input  wire logic [7:0]  i_cfg_one,
	input  wire logic [7:0]  i_cfg_two,
	input  wire logic [3:0]  i_err_inj,
	input  wire logic [7:0]  i_delay,
	// array access
	input  wire logic        i_cfg_rd,
	input  wire logic [7:0]  i_cfg_addr,
	output logic [7:0]       o_cfg_data,
	input  wire logic        i_req,
	input  wire logic [7:0]  i_cmd,
	output logic             o_done,
	output logic [31:0]      o_result,
	output logic [3:0]       o_err
);
	logic [7:0] cnt;
	logic [7:0] val;
	logic       fin;
	always_comb begin
		case (i_cfg_addr)
			8'h00: val = i_cfg_one;
			8'h01: val = i_cfg_two;
			default: val = i_cfg_addr ^ 8'ha5;
		endcase
		// unselected array shows the inverse, never a stale byte
		o_cfg_data = i_cfg_rd ? val : ~val;
	end
	// self-timed operation, restarts when the request drops
	always_ff @(posedge i_clk) begin
		o_done <= 1'b0;
		if (i_req !== 1'b1) begin
			cnt <= 8'h00;
			fin <= 1'b0;
		end else if (!fin) begin
			cnt <= cnt + 8'h01;
			if (cnt == i_delay) begin
				o_done <= 1'b1;
				fin    <= 1'b1;
			end
		end
	end
	assign o_result = o_done ? {8'hc3, 8'h5a, 8'h0f, i_cmd} : 32'h3ca5f0e1;
	assign o_err    = o_done ? i_err_inj : ~i_err_inj;
endmodule

/* fca_iap_core_test.sv */
`timescale 1ns/1ps
module fca_iap_core_test;
	import fca_pkg::*;
	logic        i_clk = 1'b0;
	logic        i_sys_rst = 1'b1;
	logic        i_cmd_valid = 1'b0;
	logic        i_key_ok = 1'b0;
	logic        i_irq_pending = 1'b0;
	logic        i_shared_pin = 1'b1;
	logic        i_wdog_timeout = 1'b0;
	logic [7:0]  i_cmd_code = 8'h00;
	logic [7:0]  i_arg_hi = 8'h12;
	logic [7:0]  i_arg_lo = 8'h34;
	logic [7:0]  i_arg_sel = 8'h00;
	logic [7:0]  cfg_one = 8'h6b;
	logic [7:0]  cfg_two = 8'h00;
	logic [7:0]  delay = 8'h02;
	logic [3:0]  err_inj = 4'h0;
	logic        o_cmd_busy, o_cmd_done, o_carry, o_cpu_release, o_fl_cfg_rd, o_fl_req;
	logic        i_fl_done, o_rc_clock_doubler, o_ext_reset, o_pin_input;
	logic        o_wdog_reset, o_wdog_irq, o_watchdog_safety_enable;
	logic [7:0]  o_res_b3, o_res_b2, o_res_b1, o_res_b0, o_fl_cfg_addr, i_fl_cfg_data;
	logic [7:0]  o_fl_cmd, o_fl_sel, cap_cmd, cap_sel, exp_b;
	logic [15:0] o_fl_addr, cap_addr;
	logic [31:0] i_fl_result;
	logic [3:0]  i_fl_err;
	logic [5:0]  o_clk_src_sel;
	logic [2:0]  o_brownout_cfg;
	logic [2:0]  osc_tab [6] = '{OSC_EXT_CLK, OSC_WDOG, OSC_INT_RC, OSC_LF_XTAL,
		OSC_MF_XTAL, OSC_HF_XTAL};
	logic        saw_req, hit;
	int          err_total = 0;
	int          total_checks = 0;
	int          cycles = 0;
	int          k;

	fca_iap_core fca_iap_core_inst (.i_clk, .i_sys_rst, .i_cmd_valid, .i_cmd_code,
		.i_arg_hi, .i_arg_lo, .i_arg_sel, .i_key_ok, .i_irq_pending, .o_cmd_busy,
		.o_cmd_done, .o_carry, .o_res_b3, .o_res_b2, .o_res_b1, .o_res_b0,
		.o_cpu_release, .o_fl_cfg_rd, .o_fl_cfg_addr, .i_fl_cfg_data, .o_fl_req,
		.o_fl_cmd, .o_fl_addr, .o_fl_sel, .i_fl_done, .i_fl_result, .i_fl_err,
		.i_shared_pin, .i_wdog_timeout, .o_clk_src_sel, .o_rc_clock_doubler,
		.o_brownout_cfg, .o_ext_reset, .o_pin_input, .o_wdog_reset, .o_wdog_irq,
		.o_watchdog_safety_enable);

	fca_flash_model fca_flash_model_inst (.i_clk(i_clk), .i_cfg_one(cfg_one),
		.i_cfg_two(cfg_two), .i_err_inj(err_inj), .i_delay(delay),
		.i_cfg_rd(o_fl_cfg_rd), .i_cfg_addr(o_fl_cfg_addr), .o_cfg_data(i_fl_cfg_data),
		.i_req(o_fl_req), .i_cmd(o_fl_cmd), .o_done(i_fl_done),
		.o_result(i_fl_result), .o_err(i_fl_err));

	always #25 i_clk = ~i_clk;

	task automatic test_done();
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	always @(posedge i_clk) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			err_total = err_total + 1;
			test_done();
		end
	end

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic do_reset(input logic [7:0] one, input logic [7:0] two);
		i_sys_rst = 1'b1;
		cfg_one = one;
		cfg_two = two;
		repeat (10) @(posedge i_clk);
		#1;
		chk8({2'b00, o_clk_src_sel}, {2'b00, SRC_RESET});
		i_sys_rst = 1'b0;
		repeat (4) @(posedge i_clk);
		#1;
		chk8({7'h00, o_cpu_release}, 8'h01);
	endtask

	// issue one call, hold it until taken, wait for its done pulse
	task automatic run_cmd(input logic [7:0] code, input logic [7:0] sel,
		input logic key, input int irq_at);
		int n;
		saw_req = 1'b0;
		i_cmd_code = code;
		i_arg_sel = sel;
		i_key_ok = key;
		i_cmd_valid = 1'b1;
		// the core sits one cycle in its done state before it takes again
		for (n = 0; n < 4 && o_cmd_busy !== 1'b1; n++) begin
			@(posedge i_clk);
			#1;
		end
		i_cmd_valid = 1'b0;
		chk8({7'h00, o_cmd_busy}, 8'h01);
		for (n = 1; n < 100 && o_cmd_done !== 1'b1; n++) begin
			if (o_fl_req === 1'b1) begin
				saw_req = 1'b1;
				cap_cmd = o_fl_cmd;
				cap_sel = o_fl_sel;
				cap_addr = o_fl_addr;
			end
			if (n == irq_at) i_irq_pending = 1'b1;
			@(posedge i_clk);
			#1;
		end
		i_irq_pending = 1'b0;
		chk8({6'h00, o_cmd_busy, o_cmd_done}, 8'h01);
	endtask

	task automatic expect_res(input logic c, input logic [7:0] b0);
		chk8({7'h00, o_carry}, {7'h00, c});
		chk8(o_res_b0, b0);
	endtask

	initial begin
		@(posedge i_clk);
		#1;
		// programmed oscillator codes stay within the six defined ones
		for (k = 0; k < 6; k++) begin
			do_reset({1'b1, 1'b0, 3'b101, osc_tab[k]}, 8'h00);
			chk8({2'b00, o_clk_src_sel}, 8'h01 << k);
			chk8({7'h00, o_rc_clock_doubler}, {7'h00, k == 2});
		end
		for (k = 0; k < 2; k++) begin
			i_shared_pin = k[0];
			repeat (2) @(posedge i_clk);
			#1;
			chk8({6'h00, o_ext_reset, o_pin_input}, {7'h00, k[0]});
		end
		do_reset(CFG1_RESET, 8'h82);
		chk8({6'h00, o_ext_reset, o_pin_input}, 8'h02);
		chk8({o_rc_clock_doubler, o_brownout_cfg, 4'h0}, 8'h50);
		chk8({7'h00, o_watchdog_safety_enable}, 8'h01);
		for (k = 0; k < 17; k++) begin
			exp_b = (k == 0) ? 8'h6b : (k == 1) ? 8'h82 : 8'(k) ^ 8'ha5;
			run_cmd(CMD_MISC_READ, 8'(k), 1'b0, 0);
			if ((k > 3 && k < 8) || k > 15) expect_res(1'b1, 8'h02);
			else expect_res(1'b0, exp_b);
		end
		// flash copy changes after start, decoded source must not
		cfg_one = 8'h00;
		run_cmd(CMD_MISC_READ, ADR_CFG_ONE, 1'b0, 0);
		expect_res(1'b0, 8'h6b);
		chk8({2'b00, o_clk_src_sel}, 8'h04);
		for (k = 0; k < 2; k++) begin
			run_cmd(CMD_ERASE, 8'(k), 1'b1, 0);
			chk8({saw_req, cap_cmd[6:0]}, 8'h84);
			chk8(cap_addr[15:8] ^ cap_addr[7:0] ^ cap_sel, 8'h26 ^ 8'(k));
			expect_res(1'b0, 8'h04);
		end
		run_cmd(CMD_ERASE, ERASE_PAGE, 1'b0, 0);
		chk8({7'h00, saw_req}, 8'h00);
		expect_res(1'b1, 8'h02);
		run_cmd(CMD_ERASE, 8'h02, 1'b1, 0);
		expect_res(1'b1, 8'h02);
		run_cmd(CMD_SECTOR_CRC, 8'h03, 1'b0, 0);
		chk8(cap_sel, 8'h03);
		chk8(o_res_b3 ^ o_res_b2 ^ o_res_b1, 8'hc3 ^ 8'h5a ^ 8'h0f);
		expect_res(1'b0, 8'h05);
		run_cmd(CMD_GLOBAL_CRC, 8'h00, 1'b0, 0);
		expect_res(1'b0, 8'h06);
		err_inj = 4'h4;
		run_cmd(CMD_SECTOR_CRC, 8'h01, 1'b0, 0);
		chk8(o_res_b3, 8'hc3);
		expect_res(1'b1, 8'h04);
		err_inj = 4'h0;
		delay = 8'd30;
		run_cmd(CMD_GLOBAL_CRC, 8'h00, 1'b0, 3);
		expect_res(1'b1, 8'h01);
		delay = 8'h01;
		run_cmd(CMD_READ_CODE, 8'h00, 1'b0, 0);
		expect_res(1'b0, 8'h07);
		for (k = 1; k >= 0; k--) begin
			i_wdog_timeout = 1'b1;
			hit = 1'b0;
			repeat (4) begin
				@(posedge i_clk);
				#1;
				hit = hit | o_wdog_reset;
			end
			chk8({7'h00, hit}, {7'h00, k[0]});
			i_wdog_timeout = 1'b0;
			if (k == 1) do_reset(CFG1_RESET, 8'h00);
		end
		chk8({6'h00, o_wdog_irq, o_watchdog_safety_enable}, 8'h02);
		test_done();
	end
endmodule
